// ==== rtl/dcf_fifo.sv ====
// Flagged FIFO with pin-side write/read ports and a Wishbone slave.
//
// What this block does
// - Shared enable/load pin high at reset: acts as second write enable.
// - Shared pin low at reset: it loads and reads back flag offsets.
// - Dual-enable mode stores a word when first enable low, second high.
// - Writes are ignored while the full flag is low.
// - One word pops per read edge with both read enables low.
// - Reads are ignored, pointer unchanged, while empty flag is low.
// - Each popped word appears as a 9-bit output word.
// - Data outputs driven while output enable low, released when high.
// - Empty flag low when nothing stored, updated on read clock.
// - Almost-empty low within offset of empty, default seven.
// - Almost-full low within offset of full, default seven.
// - Full flag low when every location used, updated on write clock.
// - Reset clears both pointers, full flags high, empty flags low.
// - Offset mode: first write enable alone governs writing.
// - Each accepted write takes a 9-bit input word.
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/100ps
module dcf_fifo #(
	parameter int DW = dcf_pkg::DCF_DATA_W,
	parameter int DEPTH = dcf_pkg::DCF_DEPTH
) (
	input logic sys_clk_in,                 // System clock, 10 MHz
	input logic reset_n_in,                 // Asynchronous reset, active low
	input logic write_clk_in,               // Writer clock pin
	input logic write_enable_first_n_in,    // First write enable, low
	input logic second_write_enable_or_offset_load_in, // Enable 2 or load
	input logic [DW-1:0] write_data_in,     // Word to write
	input logic read_clk_in,                // Reader clock pin
	input logic read_enable_first_n_in,     // First read enable, low
	input logic read_enable_second_n_in,    // Second read enable, low
	input logic output_enable_n_in,         // Output enable, low
	output logic [DW-1:0] read_data_out,    // Word read
	output logic read_data_oe_out,          // High while data driven
	output logic empty_flag_n_out,          // Empty, active low
	output logic almost_empty_flag_n_out,   // Almost empty, active low
	output logic almost_full_flag_n_out,    // Almost full, active low
	output logic full_flag_n_out,           // Full, active low
	output logic irq_out,                   // Level interrupt, high
	input logic wb_cyc_in,                  // Wishbone cycle
	input logic wb_stb_in,                  // Wishbone strobe
	input logic wb_we_in,                   // Wishbone write
	input logic [7:0] wb_adr_in,            // Wishbone byte address
	input logic [3:0] wb_sel_in,            // Wishbone byte selects
	input logic [31:0] wb_dat_in,           // Wishbone write data
	output logic [31:0] wb_dat_out,         // Wishbone read data
	output logic wb_ack_out                 // Wishbone acknowledge
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam int WS_W = DW + 3;
	localparam int WS_CLK = DW + 2;
	localparam int WS_EN1 = DW + 1;
	localparam int WS_EN2 = DW;
	localparam int RS_CLK = 3;
	localparam int RS_EN1 = 2;
	localparam int RS_EN2 = 1;
	localparam int RS_OE = 0;

	// ****************************************************************
	// Parameter checks
	// ****************************************************************
	generate
		if (DEPTH < 4 || DEPTH > 32768 ||
			(DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("DEPTH must be a power of two from 4 to 32768");
		end
		if (DW < 1 || DW > dcf_pkg::DCF_OFS_W) begin : g_bad_width
			$error("DW must be from 1 to 16");
		end
	endgenerate

	typedef struct packed {
		logic [1:0] start_cnt;
		logic dual_mode;
		logic wclk_prev;
		logic rclk_prev;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [CW-1:0] count;
		logic empty_n;
		logic ae_n;
		logic af_n;
		logic full_n;
		logic [15:0] ae_ofs;
		logic [15:0] af_ofs;
		logic ld_wr_sel;
		logic ld_rd_sel;
		logic [DW-1:0] rdata;
		logic data_oe;
		logic [3:0] int_status;
		logic [3:0] int_mask;
		logic irq;
		logic ack;
		logic [31:0] wb_rdata;
	} dcf_fifo_state_t;

	dcf_fifo_state_t st_reg;
	dcf_fifo_state_t st_next;

	logic [WS_W-1:0] wsync_q;
	logic [3:0] rsync_q;
	logic [DW-1:0] mem_rd_data;
	logic running;
	logic wr_edge;
	logic rd_edge;
	logic wr_try;
	logic ld_active;
	logic rd_try;
	logic wr_accept;
	logic rd_accept;
	logic wb_req;
	logic wb_wr;
	logic [3:0] irq_event;
	logic [3:0] irq_clear;
	logic [31:0] ofs_word;
	logic [31:0] rd_word;

	// ****************************************************************
	// Pin synchronisers and storage
	// ****************************************************************
	// Pin clocks are sampled, so they must run below a quarter of sys_clk
	dcf_sync2 #(.W(WS_W)) u_wsync (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.d_in({write_clk_in, write_enable_first_n_in,
			second_write_enable_or_offset_load_in, write_data_in}),
		.q_out(wsync_q)
	);

	dcf_sync2 #(.W(4)) u_rsync (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.d_in({read_clk_in, read_enable_first_n_in,
			read_enable_second_n_in, output_enable_n_in}),
		.q_out(rsync_q)
	);

	dcf_store #(.DW(DW), .DEPTH(DEPTH), .AW(AW)) u_store (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.wr_en_in(wr_accept),
		.wr_addr_in(st_reg.wr_ptr),
		.wr_data_in(wsync_q[DW-1:0]),
		.rd_addr_in(st_reg.rd_ptr),
		.rd_data_out(mem_rd_data)
	);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		st_next = st_reg;
		running = (st_reg.start_cnt == dcf_pkg::DCF_START_DONE);
		wr_edge = running && wsync_q[WS_CLK] && !st_reg.wclk_prev;
		rd_edge = running && rsync_q[RS_CLK] && !st_reg.rclk_prev;
		ld_active = !st_reg.dual_mode && !wsync_q[WS_EN2];
		wr_try = st_reg.dual_mode ?
			(!wsync_q[WS_EN1] && wsync_q[WS_EN2]) :
			!wsync_q[WS_EN1];
		rd_try = !rsync_q[RS_EN1] && !rsync_q[RS_EN2];
		wr_accept = 1'b0;
		rd_accept = 1'b0;
		irq_event = 4'h0;
		wb_req = wb_cyc_in && wb_stb_in;
		wb_wr = wb_req && st_reg.ack && wb_we_in;
		irq_clear = 4'h0;
		ofs_word = {st_reg.af_ofs, st_reg.ae_ofs};
		rd_word = 32'h0000_0000;
		st_next.wclk_prev = wsync_q[WS_CLK];
		st_next.rclk_prev = rsync_q[RS_CLK];
		// Synchroniser resets low, which would read as an enabled output
		st_next.data_oe = running && !rsync_q[RS_OE];

		// Mode strap is taken just after release, once the pin has synced
		if (!running) begin
			st_next.start_cnt = st_reg.start_cnt + 2'h1;
			if (st_reg.start_cnt == dcf_pkg::DCF_START_CAPTURE) begin
				st_next.dual_mode = wsync_q[WS_EN2];
			end
		end

		// Bus writes to the offsets, byte lane by byte lane
		if (wb_wr && wb_adr_in == dcf_pkg::DCF_ADR_OFFSETS) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_in[b]) begin
					ofs_word[8*b +: 8] = wb_dat_in[8*b +: 8];
				end
			end
			st_next.ae_ofs = ofs_word[dcf_pkg::DCF_OFS_AE_LSB +: 16];
			st_next.af_ofs = ofs_word[dcf_pkg::DCF_OFS_AF_LSB +: 16];
		end

		// Write side; pin offset loads override a bus write in one cycle
		if (wr_edge && ld_active && !wsync_q[WS_EN1]) begin
			if (!st_reg.ld_wr_sel) begin
				st_next.ae_ofs = 16'(wsync_q[DW-1:0]);
			end else begin
				st_next.af_ofs = 16'(wsync_q[DW-1:0]);
			end
			st_next.ld_wr_sel = !st_reg.ld_wr_sel;
		end else if (wr_edge && wr_try) begin
			if (st_reg.full_n) begin
				wr_accept = 1'b1;
				st_next.wr_ptr = st_reg.wr_ptr + AW'(1);
			end else begin
				irq_event[dcf_pkg::DCF_IRQ_WR_REFUSED] = 1'b1;
			end
		end

		// Read side; with load held low a read returns an offset instead
		if (rd_edge && rd_try) begin
			if (ld_active) begin
				st_next.rdata = st_reg.ld_rd_sel ?
					st_reg.af_ofs[DW-1:0] : st_reg.ae_ofs[DW-1:0];
				st_next.ld_rd_sel = !st_reg.ld_rd_sel;
			end else if (st_reg.empty_n) begin
				rd_accept = 1'b1;
				st_next.rdata = mem_rd_data;
				st_next.rd_ptr = st_reg.rd_ptr + AW'(1);
			end else begin
				irq_event[dcf_pkg::DCF_IRQ_RD_REFUSED] = 1'b1;
			end
		end

		st_next.count = st_reg.count + CW'(wr_accept) - CW'(rd_accept);

		// Empty side flags move only with the reader's clock
		if (rd_edge) begin
			st_next.empty_n = (st_next.count != '0);
			st_next.ae_n = (16'(st_next.count) > st_reg.ae_ofs);
		end
		// Full side flags move only with the writer's clock
		if (wr_edge) begin
			st_next.full_n = (st_next.count != CW'(DEPTH));
			st_next.af_n = ((17'(st_next.count) + 17'(st_reg.af_ofs))
				< 17'(DEPTH));
		end
		irq_event[dcf_pkg::DCF_IRQ_EMPTY] = st_reg.empty_n && !st_next.empty_n;
		irq_event[dcf_pkg::DCF_IRQ_FULL] = st_reg.full_n && !st_next.full_n;

		// Interrupt registers; a new event beats a clear in the same cycle
		if (wb_wr && wb_sel_in[0]) begin
			if (wb_adr_in == dcf_pkg::DCF_ADR_INT_STATUS) begin
				irq_clear = wb_dat_in[3:0];
			end
			if (wb_adr_in == dcf_pkg::DCF_ADR_INT_MASK) begin
				st_next.int_mask = wb_dat_in[3:0];
			end
		end
		st_next.int_status = (st_reg.int_status & ~irq_clear) | irq_event;
		st_next.irq = |(st_next.int_status & st_next.int_mask);

		// Bus answer one cycle after the request, dropped the cycle after
		st_next.ack = wb_req && !st_reg.ack;
		unique case (wb_adr_in)
			dcf_pkg::DCF_ADR_OFFSETS: begin
				rd_word = {st_reg.af_ofs, st_reg.ae_ofs};
			end
			dcf_pkg::DCF_ADR_STATUS: begin
				rd_word[dcf_pkg::DCF_ST_EMPTY] = st_reg.empty_n;
				rd_word[dcf_pkg::DCF_ST_AEMPTY] = st_reg.ae_n;
				rd_word[dcf_pkg::DCF_ST_AFULL] = st_reg.af_n;
				rd_word[dcf_pkg::DCF_ST_FULL] = st_reg.full_n;
				rd_word[dcf_pkg::DCF_ST_DUAL] = st_reg.dual_mode;
				rd_word[dcf_pkg::DCF_ST_LEVEL_LSB +: CW] = st_reg.count;
			end
			dcf_pkg::DCF_ADR_INT_STATUS: begin
				rd_word[3:0] = st_reg.int_status;
			end
			dcf_pkg::DCF_ADR_INT_MASK: begin
				rd_word[3:0] = st_reg.int_mask;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
		if (wb_req && !st_reg.ack) begin
			st_next.wb_rdata = rd_word;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_reg <= '0;
			st_reg.af_n <= 1'b1;
			st_reg.full_n <= 1'b1;
			st_reg.ae_ofs <= dcf_pkg::DCF_AE_OFS_RST;
			st_reg.af_ofs <= dcf_pkg::DCF_AF_OFS_RST;
			st_reg.int_mask <= dcf_pkg::DCF_INT_MASK_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign read_data_out = st_reg.rdata;
	assign read_data_oe_out = st_reg.data_oe;
	assign empty_flag_n_out = st_reg.empty_n;
	assign almost_empty_flag_n_out = st_reg.ae_n;
	assign almost_full_flag_n_out = st_reg.af_n;
	assign full_flag_n_out = st_reg.full_n;
	assign irq_out = st_reg.irq;
	assign wb_dat_out = st_reg.wb_rdata;
	assign wb_ack_out = st_reg.ack;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_reset_state: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		!running |-> (!empty_flag_n_out && !almost_empty_flag_n_out &&
			!read_data_oe_out &&
			almost_full_flag_n_out && full_flag_n_out &&
			st_reg.wr_ptr == '0 && st_reg.rd_ptr == '0))
		else $error("flags or pointers left reset state early");

	a_mode_strap: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		st_reg.start_cnt == dcf_pkg::DCF_START_CAPTURE |=>
			st_reg.dual_mode == $past(wsync_q[WS_EN2]) ##1
			$stable(st_reg.dual_mode))
		else $error("write mode not taken from strap");

	a_dual_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		st_reg.dual_mode && wr_edge &&
			!(!wsync_q[WS_EN1] && wsync_q[WS_EN2]) |=> $stable(st_reg.wr_ptr))
		else $error("write taken with enables not asserted");

	a_single_gate: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		!st_reg.dual_mode && wr_edge && !wsync_q[WS_EN1] &&
			wsync_q[WS_EN2] && st_reg.full_n |=>
			st_reg.wr_ptr == $past(st_reg.wr_ptr) + AW'(1))
		else $error("first enable alone did not write");

	a_full_refuse: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wr_edge && wr_try && !ld_active && !full_flag_n_out |=>
			$stable(st_reg.wr_ptr) &&
			st_reg.int_status[dcf_pkg::DCF_IRQ_WR_REFUSED])
		else $error("write accepted while full");

	a_pop_one: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		rd_edge && rd_try && !ld_active && empty_flag_n_out |=>
			st_reg.rd_ptr == $past(st_reg.rd_ptr) + AW'(1) &&
			read_data_out == $past(mem_rd_data))
		else $error("read edge did not pop one word");

	a_empty_refuse: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		rd_edge && rd_try && !ld_active && !empty_flag_n_out |=>
			$stable(st_reg.rd_ptr) && $stable(read_data_out))
		else $error("read accepted while empty");

	a_empty_value: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		rd_edge |=> empty_flag_n_out == (st_reg.count != '0))
		else $error("empty flag wrong after read edge");

	a_full_value: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wr_edge |=> full_flag_n_out == (st_reg.count != CW'(DEPTH)))
		else $error("full flag wrong after write edge");

	a_aempty_value: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		rd_edge |=> almost_empty_flag_n_out ==
			(16'(st_reg.count) > $past(st_reg.ae_ofs)))
		else $error("almost-empty flag wrong after read edge");

	a_afull_value: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wr_edge |=> almost_full_flag_n_out ==
			((17'(st_reg.count) + 17'($past(st_reg.af_ofs))) < 17'(DEPTH)))
		else $error("almost-full flag wrong after write edge");

	a_oe_follow: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		running |=> read_data_oe_out == !$past(rsync_q[RS_OE]))
		else $error("data enable does not follow output enable");

	a_irq_level: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		irq_out == |(st_reg.int_status & st_reg.int_mask))
		else $error("interrupt does not match masked status");

	a_ack_pulse: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack held two cycles");

endmodule : dcf_fifo

// ==== inc/dcf_pkg.sv ====
// Shared constants of the flagged FIFO port block: sizes, map, fields.
package dcf_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int DCF_DATA_W = 9;
	localparam int DCF_DEPTH = 256;
	localparam int DCF_OFS_W = 16;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] DCF_ADR_OFFSETS = 8'h00;
	localparam logic [7:0] DCF_ADR_STATUS = 8'h04;
	localparam logic [7:0] DCF_ADR_INT_STATUS = 8'h08;
	localparam logic [7:0] DCF_ADR_INT_MASK = 8'h0c;

	// ****************************************************************
	// Fields and reset values
	// ****************************************************************
	localparam int DCF_OFS_AE_LSB = 0;
	localparam int DCF_OFS_AF_LSB = 16;
	localparam logic [15:0] DCF_AE_OFS_RST = 16'h0007;
	localparam logic [15:0] DCF_AF_OFS_RST = 16'h0007;
	localparam int DCF_ST_EMPTY = 0;
	localparam int DCF_ST_AEMPTY = 1;
	localparam int DCF_ST_AFULL = 2;
	localparam int DCF_ST_FULL = 3;
	localparam int DCF_ST_DUAL = 4;
	localparam int DCF_ST_LEVEL_LSB = 16;
	localparam int DCF_IRQ_W = 4;
	localparam int DCF_IRQ_EMPTY = 0;
	localparam int DCF_IRQ_FULL = 1;
	localparam int DCF_IRQ_WR_REFUSED = 2;
	localparam int DCF_IRQ_RD_REFUSED = 3;
	localparam logic [3:0] DCF_INT_MASK_RST = 4'h0;

	// ****************************************************************
	// Start-up sequence after reset release
	// ****************************************************************
	localparam logic [1:0] DCF_START_CAPTURE = 2'h2;
	localparam logic [1:0] DCF_START_DONE = 2'h3;

endpackage : dcf_pkg

// ==== rtl/dcf_sync2.sv ====
// Two-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/100ps
module dcf_sync2 #(
	parameter int W = 1
) (
	input logic sys_clk_in,   // System clock
	input logic reset_n_in,   // Asynchronous reset, active low
	input logic [W-1:0] d_in, // Asynchronous pin levels
	output logic [W-1:0] q_out // Levels after two flops
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dcf_sync_state_t;

	dcf_sync_state_t st_reg;
	dcf_sync_state_t st_next;

	// First stage feeds only the second one
	always_comb begin
		st_next = st_reg;
		st_next.s1 = d_in;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_out = st_reg.s2;

endmodule : dcf_sync2

// ==== rtl/dcf_store.sv ====
// Flip-flop word storage of the FIFO, one write and one read address.
`timescale 1ns/100ps
module dcf_store #(
	parameter int DW = 9,
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input logic sys_clk_in,          // System clock
	input logic reset_n_in,          // Asynchronous reset, active low
	input logic wr_en_in,            // Store word this cycle
	input logic [AW-1:0] wr_addr_in, // Write location
	input logic [DW-1:0] wr_data_in, // Word to store
	input logic [AW-1:0] rd_addr_in, // Read location
	output logic [DW-1:0] rd_data_out // Word at read location
);
	generate
		if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_depth
			$error("DEPTH must fit the address width");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] mem;
	} dcf_store_state_t;

	dcf_store_state_t st_reg;
	dcf_store_state_t st_next;

	always_comb begin
		st_next = st_reg;
		if (wr_en_in) begin
			st_next.mem[wr_addr_in] = wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data_out = st_reg.mem[rd_addr_in];

endmodule : dcf_store

// ==== dv/dcf_pins.sv ====
// Pin-side writer and reader model that clocks words through the FIFO.
`timescale 1ns/100ps
module dcf_pins (
	input logic clk_in,          // System clock pacing the pins
	input logic strap_in,        // Idle level of the shared pin
	output logic wr_clk_out,     // Writer clock
	output logic wr_en1_n_out,   // First write enable
	output logic pin2_out,       // Shared enable/load pin
	output logic [8:0] wr_dat_out, // Word to write
	output logic rd_clk_out,     // Reader clock
	output logic rd_en1_n_out,   // First read enable
	output logic rd_en2_n_out    // Second read enable
);
	logic use_pin = 1'b0;
	logic req_pin = 1'b0;
	// Idle shared pin rests at the strap level so the mode never flips
	assign pin2_out = use_pin ? req_pin : strap_in;
	initial begin
		wr_clk_out = 1'b0;
		wr_en1_n_out = 1'b1;
		wr_dat_out = 9'h000;
		rd_clk_out = 1'b0;
		rd_en1_n_out = 1'b1;
		rd_en2_n_out = 1'b1;
	end
	// ****************************************************************
	// One writer clock period and one reader clock period
	// ****************************************************************
	task automatic put(input logic e1_n, input logic p2, input logic [8:0] d);
		@(posedge clk_in);
		wr_en1_n_out <= e1_n;
		req_pin <= p2;
		use_pin <= 1'b1;
		wr_dat_out <= d;
		repeat (2) @(posedge clk_in);
		wr_clk_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		wr_clk_out <= 1'b0;
		wr_en1_n_out <= 1'b1;
		use_pin <= 1'b0;
		// Past the hold time the old word is no longer offered
		wr_dat_out <= ~d;
		repeat (3) @(posedge clk_in);
	endtask : put
	task automatic get(input logic r1_n, input logic r2_n);
		@(posedge clk_in);
		rd_en1_n_out <= r1_n;
		rd_en2_n_out <= r2_n;
		repeat (2) @(posedge clk_in);
		rd_clk_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		rd_clk_out <= 1'b0;
		rd_en1_n_out <= 1'b1;
		rd_en2_n_out <= 1'b1;
		repeat (3) @(posedge clk_in);
	endtask : get
endmodule : dcf_pins

// ==== dv/tb.sv ====
// Self-checking bench of the flagged FIFO ports and its register slave.
`timescale 1ns/100ps
module tb;
	localparam int DEPTH = 16;
	localparam logic [7:0] A_OFS = dcf_pkg::DCF_ADR_OFFSETS;
	localparam logic [7:0] A_ST = dcf_pkg::DCF_ADR_STATUS;
	localparam logic [7:0] A_IS = dcf_pkg::DCF_ADR_INT_STATUS;
	localparam logic [7:0] A_IM = dcf_pkg::DCF_ADR_INT_MASK;
	typedef struct packed {
		logic en1_n;
		logic en2;
		logic [8:0] dat;
		logic [4:0] lvl;
	} dcf_row_t;
	localparam dcf_row_t ROWS [4] = '{'{1'b0, 1'b1, 9'h155, 5'h1},
		'{1'b1, 1'b1, 9'h0aa, 5'h1}, '{1'b0, 1'b0, 9'h0f0, 5'h1},
		'{1'b1, 1'b0, 9'h00f, 5'h1}};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic strap = 1'b1;
	logic oe_n = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, rd;
	logic ack, irq, wclk, en1_n, pin2, rclk, r1_n, r2_n, q_oe;
	logic [8:0] dat, q;
	logic [3:0] flg;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	always #50 clk = ~clk;
	dcf_pins u_pin (.clk_in(clk), .strap_in(strap), .wr_clk_out(wclk),
		.wr_en1_n_out(en1_n), .pin2_out(pin2), .wr_dat_out(dat),
		.rd_clk_out(rclk), .rd_en1_n_out(r1_n), .rd_en2_n_out(r2_n));
	dcf_fifo #(.DW(9), .DEPTH(DEPTH)) dut (.sys_clk_in(clk),
		.reset_n_in(rst_n), .write_clk_in(wclk),
		.write_enable_first_n_in(en1_n),
		.second_write_enable_or_offset_load_in(pin2),
		.write_data_in(dat), .read_clk_in(rclk),
		.read_enable_first_n_in(r1_n), .read_enable_second_n_in(r2_n),
		.output_enable_n_in(oe_n), .read_data_out(q),
		.read_data_oe_out(q_oe), .empty_flag_n_out(flg[0]),
		.almost_empty_flag_n_out(flg[1]), .almost_full_flag_n_out(flg[2]),
		.full_flag_n_out(flg[3]), .irq_out(irq), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic lvl_is(input logic [4:0] exp);
		wb(1'b0, A_ST, 32'h0);
		chk(32'(rd[20:16]), 32'(exp));
	endtask : lvl_is
	task automatic do_reset(input logic s);
		@(posedge clk);
		strap <= s;
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		chk(flg, 4'hc);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk(q_oe, 1'b0);
		repeat (4) @(posedge clk);
	endtask : do_reset
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			test_done();
		end
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		do_reset(1'b1);
		wb(1'b0, A_ST, 32'h0);
		chk(rd[4], 1'b1);
		chk(rd[3:0], 4'hc);
		wb(1'b0, A_OFS, 32'h0);
		chk(rd, 32'h0007_0007);
		wb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		foreach (ROWS[i]) begin
			u_pin.put(ROWS[i].en1_n, ROWS[i].en2, ROWS[i].dat);
			lvl_is(ROWS[i].lvl);
		end
		u_pin.get(1'b1, 1'b1);
		chk(flg[0], 1'b1);
		u_pin.get(1'b0, 1'b1);
		lvl_is(5'h1);
		u_pin.get(1'b0, 1'b0);
		chk(q, 9'h155);
		chk(flg[0], 1'b0);
		oe_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk(q_oe, 1'b1);
		oe_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk(q_oe, 1'b0);
		for (int i = 0; i < DEPTH; i++) begin
			u_pin.put(1'b0, 1'b1, 9'h100 | 9'(i));
			chk(flg[2], i + 1 < DEPTH - 7);
			chk(flg[3], i + 1 < DEPTH);
		end
		wb(1'b1, A_IM, 32'h4);
		u_pin.put(1'b0, 1'b1, 9'h0ff);
		lvl_is(5'h10);
		chk(irq, 1'b1);
		wb(1'b1, A_IS, 32'hf);
		wb(1'b0, A_IS, 32'h0);
		chk(rd[2], 1'b0);
		chk(irq, 1'b0);
		// Empty side only learns of the writes on a reader clock edge
		u_pin.get(1'b1, 1'b1);
		for (int i = 0; i < DEPTH; i++) begin
			u_pin.get(1'b0, 1'b0);
			chk(q, 9'h100 | 9'(i));
			chk(flg[1], DEPTH - 1 - i > 7);
			chk(flg[0], i != DEPTH - 1);
		end
		wb(1'b1, A_IM, 32'h8);
		u_pin.get(1'b0, 1'b0);
		chk(q, 9'h10f);
		lvl_is(5'h0);
		chk(irq, 1'b1);
		do_reset(1'b0);
		wb(1'b0, A_ST, 32'h0);
		chk(rd[4], 1'b0);
		u_pin.put(1'b0, 1'b0, 9'h003);
		u_pin.put(1'b0, 1'b0, 9'h005);
		wb(1'b0, A_OFS, 32'h0);
		chk(rd, 32'h0005_0003);
		u_pin.get(1'b0, 1'b0);
		chk(q, 9'h003);
		lvl_is(5'h0);
		u_pin.put(1'b0, 1'b1, 9'h1aa);
		lvl_is(5'h1);
		u_pin.put(1'b1, 1'b1, 9'h055);
		lvl_is(5'h1);
		test_done();
	end
endmodule : tb
